// ---- hw/ohci_regs_pkg.sv ----
package ohci_regs_pkg;

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int CHAN_W = 64;
    localparam int GP_W = 2;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] CHMASK_HI_SET = 8'h70;
    localparam logic [7:0] CHMASK_HI_CLR = 8'h74;
    localparam logic [7:0] CHMASK_LO_SET = 8'h78;
    localparam logic [7:0] CHMASK_LO_CLR = 8'h7C;
    localparam logic [7:0] EVT_SET       = 8'h80;
    localparam logic [7:0] EVT_CLR       = 8'h84;
    localparam logic [7:0] IRQ_MASK      = 8'h88;
    localparam logic [7:0] CTRL          = 8'h8C;
    localparam logic [7:0] STATUS        = 8'h90;

    // event register layout
    localparam logic [31:0] EVT_VALID = 32'h6FFF_83FF;
    localparam int GP_EVT_BIT    = 30;
    localparam int SW_EVT_BIT    = 29;
    localparam int TARDY_EVT_BIT = 27;

    // control register layout
    localparam logic [31:0] CTRL_VALID = 32'hA080_0000;
    localparam int GP_HI_EN_BIT = 31;
    localparam int TARDY_EN_BIT = 29;
    localparam int GP_LO_EN_BIT = 23;

    // status register layout
    localparam int ST_FIFO_BIT  = 0;
    localparam int ST_GP_LO_BIT = 1;
    localparam int ST_GP_HI_BIT = 2;
    localparam int ST_IRQ_BIT   = 3;

    // reset values
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] EVT_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_W   = 32'h0000_0000;

endpackage

// ---- hw/regbus_if.sv ----
`timescale 1ns/1ps
interface regbus_if;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic        ack;
    logic        wr_stb;
    logic        rd_ld;
    logic [31:0] wmask;

    modport port
    (
        input  cyc, stb, we, sel,
        output ack, wr_stb, rd_ld, wmask
    );
    modport regs
    (
        output cyc, stb, we, sel,
        input  ack, wr_stb, rd_ld, wmask
    );
endinterface

// ---- hw/wb_slave_port.sv ----
`timescale 1ns/1ps
module wb_slave_port
(
    input wire logic clk,      // controller clock
    input wire logic rst,      // synchronous reset, high
    regbus_if.port   bus       // decoded register strobes
);
    logic ack_q;
    logic ack_d;
    wire  req;

    assign req = bus.cyc & bus.stb;
    // one wait cycle, then a single-cycle ack
    assign ack_d = req & ~ack_q;
    assign bus.ack = ack_q;
    // writes land on the edge where the master sees ack
    assign bus.wr_stb = req & ack_q & bus.we;
    // read data is captured on the edge that raises ack
    assign bus.rd_ld = ack_d & ~bus.we;

    genvar g;
    generate
        for (g = 0; g < ohci_regs_pkg::SEL_W; g++)
        begin : g_lane
            assign bus.wmask[8*g +: 8] = {8{bus.sel[g]}};
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= ack_d;
    end

    a_ack_single_pulse:
    assert property (@(posedge clk) disable iff (rst)
        ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

    a_ack_after_req:
    assert property (@(posedge clk) disable iff (rst)
        $rose(ack_q) |-> $past(req) && !$past(ack_q))
    else $error("ack raised without a request");
endmodule

// ---- hw/iso_rx_mask_and_irq_event_regs.sv ----
`timescale 1ns/1ps
module iso_rx_mask_and_irq_event_regs
(
    input  wire logic        CLK,             // 20 MHz controller clock
    input  wire logic        SYS_RST,         // synchronous reset, high
    input  wire logic        WB_CYC_I,        // wishbone cycle
    input  wire logic        WB_STB_I,        // wishbone strobe
    input  wire logic        WB_WE_I,         // wishbone write enable
    input  wire logic [7:0]  WB_ADR_I,        // wishbone byte address
    input  wire logic [31:0] WB_DAT_I,        // wishbone write data
    input  wire logic [3:0]  WB_SEL_I,        // wishbone byte selects
    output logic             WB_ACK_O,        // wishbone acknowledge
    output logic      [31:0] WB_DAT_O,        // wishbone read data
    input  wire logic [1:0]  GP_IRQ,          // general-purpose irq pins
    input  wire logic        RX_FIFO_PENDING, // receive data awaits host
    input  wire logic [31:0] EVENT_SRC,       // other event source levels
    output logic      [63:0] RX_CHAN_EN,      // per-channel receive enable
    output logic             IRQ              // level interrupt request
);
    regbus_if bus ();

    assign bus.cyc = WB_CYC_I;
    assign bus.stb = WB_STB_I;
    assign bus.we  = WB_WE_I;
    assign bus.sel = WB_SEL_I;

    wb_slave_port u_port
    (
        .clk (CLK),
        .rst (SYS_RST),
        .bus (bus)
    );

    assign WB_ACK_O = bus.ack;

    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // storage
    logic [31:0] mask_lo_q;
    logic [31:0] mask_lo_d;
    logic [31:0] mask_hi_q;
    logic [31:0] mask_hi_d;
    logic [31:0] ev_q;
    logic [31:0] ev_d;
    logic [31:0] irqm_q;
    logic [31:0] irqm_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] src_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        irq_q;
    logic        irq_d;
    logic [1:0]  gp_s1_q;
    logic [1:0]  gp_s2_q;

    // address decode
    wire h_hi_set = hit(WB_ADR_I, ohci_regs_pkg::CHMASK_HI_SET);
    wire h_hi_clr = hit(WB_ADR_I, ohci_regs_pkg::CHMASK_HI_CLR);
    wire h_lo_set = hit(WB_ADR_I, ohci_regs_pkg::CHMASK_LO_SET);
    wire h_lo_clr = hit(WB_ADR_I, ohci_regs_pkg::CHMASK_LO_CLR);
    wire h_ev_set = hit(WB_ADR_I, ohci_regs_pkg::EVT_SET);
    wire h_ev_clr = hit(WB_ADR_I, ohci_regs_pkg::EVT_CLR);
    wire h_irqm   = hit(WB_ADR_I, ohci_regs_pkg::IRQ_MASK);
    wire h_ctrl   = hit(WB_ADR_I, ohci_regs_pkg::CTRL);
    wire h_stat   = hit(WB_ADR_I, ohci_regs_pkg::STATUS);

    wire [31:0] w_bits = WB_DAT_I & bus.wmask;

    wire wr_hi_set = bus.wr_stb & h_hi_set;
    wire wr_hi_clr = bus.wr_stb & h_hi_clr;
    wire wr_lo_set = bus.wr_stb & h_lo_set;
    wire wr_lo_clr = bus.wr_stb & h_lo_clr;
    wire wr_ev_set = bus.wr_stb & h_ev_set;
    wire wr_ev_clr = bus.wr_stb & h_ev_clr;
    wire wr_irqm   = bus.wr_stb & h_irqm;
    wire wr_ctrl   = bus.wr_stb & h_ctrl;

    // channel masks: set and clear offsets act on one store
    assign mask_lo_d = wr_lo_set ? (mask_lo_q | w_bits)  :
                       wr_lo_clr ? (mask_lo_q & ~w_bits) :
                       mask_lo_q;
    assign mask_hi_d = wr_hi_set ? (mask_hi_q | w_bits)  :
                       wr_hi_clr ? (mask_hi_q & ~w_bits) :
                       mask_hi_q;

    // control and interrupt mask honour byte selects
    assign irqm_d = wr_irqm ? ((irqm_q & ~bus.wmask) | w_bits) : irqm_q;
    assign ctrl_d = wr_ctrl
                  ? (((ctrl_q & ~bus.wmask) | w_bits)
                     & ohci_regs_pkg::CTRL_VALID)
                  : ctrl_q;

    // hardware event levels
    wire gp_lvl = (gp_s2_q[1] & ctrl_q[ohci_regs_pkg::GP_HI_EN_BIT])
                | (gp_s2_q[0] & ctrl_q[ohci_regs_pkg::GP_LO_EN_BIT]);
    wire tardy_lvl = ctrl_q[ohci_regs_pkg::TARDY_EN_BIT]
                   & RX_FIFO_PENDING;

    logic [31:0] src_lvl;
    genvar i;
    generate
        for (i = 0; i < ohci_regs_pkg::DAT_W; i++)
        begin : g_src
            if (i == ohci_regs_pkg::GP_EVT_BIT)
            begin : g_gp
                assign src_lvl[i] = gp_lvl;
            end
            else if (i == ohci_regs_pkg::TARDY_EVT_BIT)
            begin : g_tardy
                assign src_lvl[i] = tardy_lvl;
            end
            else if (i == ohci_regs_pkg::SW_EVT_BIT)
            begin : g_sw
                assign src_lvl[i] = 1'b0;
            end
            else
            begin : g_gen
                assign src_lvl[i] = EVENT_SRC[i]
                                  & ohci_regs_pkg::EVT_VALID[i];
            end
        end
    endgenerate

    wire [31:0] rise_v = src_lvl & ~src_q;
    wire [31:0] sw_set = wr_ev_set ? w_bits : ohci_regs_pkg::ZERO_W;
    wire [31:0] sw_clr = wr_ev_clr ? w_bits : ohci_regs_pkg::ZERO_W;

    // a set arriving with a clear wins; reserved bits never store
    assign ev_d = ((ev_q & ~sw_clr) | sw_set | rise_v)
                & ohci_regs_pkg::EVT_VALID;

    wire [31:0] ev_masked = ev_q & irqm_q;

    assign irq_d = |(ev_d & irqm_d);

    // status word: live levels seen by the block
    wire [31:0] stat_w = (32'(RX_FIFO_PENDING) << ohci_regs_pkg::ST_FIFO_BIT)
                       | (32'(gp_s2_q[0]) << ohci_regs_pkg::ST_GP_LO_BIT)
                       | (32'(gp_s2_q[1]) << ohci_regs_pkg::ST_GP_HI_BIT)
                       | (32'(irq_q) << ohci_regs_pkg::ST_IRQ_BIT);

    // read selection; unmapped addresses read as zero
    wire [31:0] rd_val = (h_hi_set | h_hi_clr) ? mask_hi_q :
                         (h_lo_set | h_lo_clr) ? mask_lo_q :
                         (h_ev_set | h_ev_clr) ? ev_masked :
                         h_irqm ? irqm_q :
                         h_ctrl ? ctrl_q :
                         h_stat ? stat_w :
                         ohci_regs_pkg::ZERO_W;

    assign rdata_d = bus.rd_ld ? rd_val : rdata_q;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            mask_lo_q <= ohci_regs_pkg::MASK_RST;
            mask_hi_q <= ohci_regs_pkg::MASK_RST;
        end
        else
        begin
            mask_lo_q <= mask_lo_d;
            mask_hi_q <= mask_hi_d;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ev_q  <= ohci_regs_pkg::EVT_RST;
            src_q <= ohci_regs_pkg::ZERO_W;
            irq_q <= 1'b0;
        end
        else
        begin
            ev_q  <= ev_d;
            src_q <= src_lvl;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            irqm_q <= ohci_regs_pkg::MASK_RST;
            ctrl_q <= ohci_regs_pkg::CTRL_RST;
        end
        else
        begin
            irqm_q <= irqm_d;
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            rdata_q <= ohci_regs_pkg::ZERO_W;
        else
            rdata_q <= rdata_d;
    end

    // pin synchroniser; only the second stage is read
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            gp_s1_q <= 2'h0;
            gp_s2_q <= 2'h0;
        end
        else
        begin
            gp_s1_q <= GP_IRQ;
            gp_s2_q <= gp_s1_q;
        end
    end

    assign RX_CHAN_EN = {mask_hi_q, mask_lo_q};
    assign WB_DAT_O   = rdata_q;
    assign IRQ        = irq_q;

    a_low_mask_set:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_lo_set |=>
            (RX_CHAN_EN[31:0] & $past(w_bits)) == $past(w_bits))
    else $error("low mask set write did not enable channels");

    a_high_mask_clr:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_hi_clr |=>
            (RX_CHAN_EN[33:32] & $past(w_bits[1:0])) == 2'h0)
    else $error("high mask clear write left channel 32/33 on");

    a_low_mask_keep:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_lo_clr |=>
            (mask_lo_q & ~$past(w_bits))
                == ($past(mask_lo_q) & ~$past(w_bits)))
    else $error("low mask clear disturbed unselected channels");

    a_mask_readback:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        bus.rd_ld && (h_hi_set || h_hi_clr) ##1 bus.ack
            |-> WB_DAT_O == $past(mask_hi_q))
    else $error("high mask read returned wrong contents");

    a_event_edge_set:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        (rise_v != ohci_regs_pkg::ZERO_W) |=>
            (ev_q & $past(rise_v)) == $past(rise_v))
    else $error("source edge did not set its event bit");

    a_event_no_clear:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        !wr_ev_clr |=> ($past(ev_q) & ~ev_q) == ohci_regs_pkg::ZERO_W)
    else $error("event bit dropped without a clear write");

    a_event_read_masked:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        bus.rd_ld && (h_ev_set || h_ev_clr) ##1 bus.ack
            |-> WB_DAT_O == $past(ev_masked))
    else $error("event read not masked by interrupt mask");

    a_gp_event:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(gp_lvl) |=> ev_q[ohci_regs_pkg::GP_EVT_BIT])
    else $error("general-purpose irq did not set event 30");

    a_soft_only:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(ev_q[ohci_regs_pkg::SW_EVT_BIT])
            |-> $past(sw_set[ohci_regs_pkg::SW_EVT_BIT]))
    else $error("software event set without a set write");

    a_reserved_zero:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        !ev_q[31] && !ev_q[28] && !ev_masked[31] && !ev_masked[28])
    else $error("reserved event bit is set");

    a_tardy_event:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        ctrl_q[ohci_regs_pkg::TARDY_EN_BIT] && RX_FIFO_PENDING
            && !src_q[ohci_regs_pkg::TARDY_EVT_BIT]
            |=> ev_q[ohci_regs_pkg::TARDY_EVT_BIT])
    else $error("tardy condition did not set event 27");

    a_irq_follows_events:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        IRQ == (|(ev_q & irqm_q)))
    else $error("interrupt output disagrees with masked events");

    a_high_mask_set:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_hi_set |=>
            (RX_CHAN_EN[63:32] & $past(w_bits)) == $past(w_bits))
    else $error("high mask set write did not enable channels");

    a_low_mask_clr:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_lo_clr |=>
            (RX_CHAN_EN[31:0] & $past(w_bits)) == ohci_regs_pkg::ZERO_W)
    else $error("low mask clear write left channels on");

    a_event_set_write:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_ev_set |=> (ev_q & $past(w_bits))
            == ($past(w_bits) & ohci_regs_pkg::EVT_VALID))
    else $error("set write did not set its event bits");

    a_event_clear_write:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_ev_clr |=> (ev_q & $past(w_bits) & ~$past(rise_v))
            == ohci_regs_pkg::ZERO_W)
    else $error("clear write left its event bits set");

    a_sw_event_set:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_ev_set && w_bits[ohci_regs_pkg::SW_EVT_BIT]
            |=> ev_q[ohci_regs_pkg::SW_EVT_BIT])
    else $error("software event not set by its set write");

    a_tardy_needs_en:
    assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(ev_q[ohci_regs_pkg::TARDY_EVT_BIT])
            |-> $past(ctrl_q[ohci_regs_pkg::TARDY_EN_BIT])
                || $past(sw_set[ohci_regs_pkg::TARDY_EVT_BIT]))
    else $error("tardy event set while tardy ack disabled");
endmodule

// ---- testbench/iso_rx_mask_and_irq_event_regs_tb.sv ----
`timescale 1ns/1ps
module iso_rx_mask_and_irq_event_regs_tb;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        ack;
    logic [31:0] dout;
    logic [1:0]  gp;
    logic        fifo;
    logic [31:0] src;
    logic [63:0] chan;
    logic        irq;
    int          n_mismatch;
    int          checked;
    logic [31:0] m_lo, m_hi, m_evt, m_im, m_ctl, rd, v;

    iso_rx_mask_and_irq_event_regs iso_rx_mask_and_irq_event_regs_i
    (
        .CLK             (clk),
        .SYS_RST         (rst),
        .WB_CYC_I        (cyc),
        .WB_STB_I        (stb),
        .WB_WE_I         (we),
        .WB_ADR_I        (adr),
        .WB_DAT_I        (dat),
        .WB_SEL_I        (sel),
        .WB_ACK_O        (ack),
        .WB_DAT_O        (dout),
        .GP_IRQ          (gp),
        .RX_FIFO_PENDING (fifo),
        .EVENT_SRC       (src),
        .RX_CHAN_EN      (chan),
        .IRQ             (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ln(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // one classic cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int          i;
        logic [31:0] lm;
        lm = ln(s) & d;
        i = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1 && i < 20)
        begin
            @(posedge clk);
            i++;
        end
        if (ack !== 1'b1)
        begin
            n_mismatch++;
            final_report;
        end
        // ack sampled high at this edge: the write lands, read data is taken
        rd = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (w)
            case (a)
                ohci_regs_pkg::CHMASK_HI_SET: m_hi = m_hi | lm;
                ohci_regs_pkg::CHMASK_HI_CLR: m_hi = m_hi & ~lm;
                ohci_regs_pkg::CHMASK_LO_SET: m_lo = m_lo | lm;
                ohci_regs_pkg::CHMASK_LO_CLR: m_lo = m_lo & ~lm;
                ohci_regs_pkg::EVT_SET: m_evt = m_evt | lm;
                ohci_regs_pkg::EVT_CLR: m_evt = m_evt & ~lm;
                ohci_regs_pkg::IRQ_MASK: m_im = (m_im & ~ln(s)) | lm;
                ohci_regs_pkg::CTRL: m_ctl = (m_ctl & ~ln(s)) | lm;
                default: ;
            endcase
        m_evt = m_evt & ohci_regs_pkg::EVT_VALID;
        m_ctl = m_ctl & ohci_regs_pkg::CTRL_VALID;
        @(posedge clk);
    endtask

    // read one place and compare with the model
    task automatic rc(input logic [7:0] a);
        logic [31:0] e;
        wb(1'b0, a, 32'h0000_0000, 4'hF);
        case (a)
            ohci_regs_pkg::CHMASK_HI_SET,
            ohci_regs_pkg::CHMASK_HI_CLR: e = m_hi;
            ohci_regs_pkg::CHMASK_LO_SET,
            ohci_regs_pkg::CHMASK_LO_CLR: e = m_lo;
            ohci_regs_pkg::EVT_SET,
            ohci_regs_pkg::EVT_CLR: e = m_evt & m_im;
            ohci_regs_pkg::IRQ_MASK: e = m_im;
            ohci_regs_pkg::CTRL: e = m_ctl;
            ohci_regs_pkg::STATUS:
                e = {28'h000_0000, |(m_evt & m_im), gp, fifo};
            default: e = 32'h0000_0000;
        endcase
        chk(rd, e);
        chk({31'h0000_0000, irq}, {31'h0000_0000, |(m_evt & m_im)});
    endtask

    initial
    begin
        void'($urandom(32'h2386));
        {cyc, stb, we, adr, dat, sel} = '0;
        {gp, fifo, src} = '0;
        {m_lo, m_hi, m_evt, m_im, m_ctl} = '0;
        n_mismatch = 0;
        checked = 0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(chan[31:0] | chan[63:32], 32'h0000_0000);
        for (int n = 0; n < 34; n++)
        begin
            wb(1'b1, ohci_regs_pkg::CHMASK_LO_CLR,
               32'hFFFF_FFFF, 4'hF);
            wb(1'b1, ohci_regs_pkg::CHMASK_HI_CLR,
               32'hFFFF_FFFF, 4'hF);
            v = 32'h0000_0001 << (n % 32);
            wb(1'b1, (n < 32) ? ohci_regs_pkg::CHMASK_LO_SET
                              : ohci_regs_pkg::CHMASK_HI_SET, v, 4'hF);
            chk(chan[31:0], m_lo);
            chk(chan[63:32], m_hi);
        end
        for (int k = 0; k < 3; k++)
        begin
            wb(1'b1, ohci_regs_pkg::CHMASK_LO_SET, $urandom, 4'($urandom));
            wb(1'b1, ohci_regs_pkg::CHMASK_HI_SET, $urandom, 4'hF);
            wb(1'b1, ohci_regs_pkg::CHMASK_LO_CLR, $urandom, 4'($urandom));
            wb(1'b1, ohci_regs_pkg::CHMASK_HI_CLR, $urandom, 4'($urandom));
            for (int a = 8'h70; a < 8'h80; a += 4)
                rc(a[7:0]);
            chk(chan[31:0], m_lo);
        end
        wb(1'b1, ohci_regs_pkg::IRQ_MASK, 32'hFFFF_FFFF, 4'hF);
        wb(1'b1, ohci_regs_pkg::EVT_SET, 32'hFFFF_FFFF, 4'hF);
        rc(ohci_regs_pkg::EVT_SET);
        rc(ohci_regs_pkg::EVT_CLR);
        wb(1'b1, ohci_regs_pkg::IRQ_MASK, $urandom, 4'hF);
        rc(ohci_regs_pkg::EVT_CLR);
        wb(1'b1, ohci_regs_pkg::EVT_CLR, $urandom, 4'($urandom));
        rc(ohci_regs_pkg::EVT_SET);
        wb(1'b1, ohci_regs_pkg::EVT_CLR, 32'hFFFF_FFFF, 4'hF);
        wb(1'b1, ohci_regs_pkg::IRQ_MASK, 32'hFFFF_FFFF, 4'hF);
        wb(1'b1, ohci_regs_pkg::EVT_SET, 32'h2000_0000, 4'h8);
        rc(ohci_regs_pkg::EVT_SET);
        v = $urandom & ohci_regs_pkg::EVT_VALID & 32'h07FF_FFFF;
        src <= v;
        repeat (3) @(posedge clk);
        m_evt = m_evt | v;
        src <= 32'h0000_0000;
        repeat (2) @(posedge clk);
        rc(ohci_regs_pkg::EVT_SET);
        wb(1'b1, ohci_regs_pkg::EVT_CLR, 32'hFFFF_FFFF, 4'hF);
        // each enable in turn: the other pin first must not set the event
        for (int j = 0; j < 2; j++)
        begin
            wb(1'b1, ohci_regs_pkg::CTRL, j ? 32'h0080_0000 : 32'h8000_0000,
               4'hF);
            gp <= j ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk);
            rc(ohci_regs_pkg::EVT_SET);
            gp <= 2'b11;
            repeat (6) @(posedge clk);
            m_evt[30] = 1'b1;
            rc(ohci_regs_pkg::EVT_SET);
            gp <= 2'b00;
            wb(1'b1, ohci_regs_pkg::EVT_CLR, 32'h4000_0000, 4'hF);
        end
        wb(1'b1, ohci_regs_pkg::CTRL, 32'h0000_0000, 4'hF);
        fifo <= 1'b1;
        repeat (3) @(posedge clk);
        rc(ohci_regs_pkg::EVT_SET);
        wb(1'b1, ohci_regs_pkg::CTRL, 32'h2000_0000, 4'hF);
        repeat (3) @(posedge clk);
        m_evt[27] = 1'b1;
        rc(ohci_regs_pkg::EVT_CLR);
        rc(ohci_regs_pkg::IRQ_MASK);
        rc(ohci_regs_pkg::CTRL);
        rc(ohci_regs_pkg::STATUS);
        rc(8'h40);
        final_report;
    end
endmodule
